//--- shared/itp_pkg.sv
package itp_pkg;

  // Fixed target address and the direction bit values of the address byte
  localparam logic [6:0] TGT_ADDR = 7'h6c;
  localparam logic DIR_READ = 1'h1;
  localparam logic DIR_WRITE = 1'h0;

  // Byte framing: eight data bits, the ninth clock carries the acknowledge
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int DATA_MSB = 7;

  // Register pointer after reset
  localparam logic [7:0] PTR_RST = 8'h00;

  // Serial clock timing of the master end
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [6:0] QUARTER_LAST = 7'(QUARTER_CYC - 1);

  // Depth of the command queue in front of the master end
  localparam int CMD_DEPTH = 8;

  // Master command kinds; START doubles as a repeated START
  typedef enum logic [1:0] {
    ITP_CMD_START,
    ITP_CMD_WRITE,
    ITP_CMD_READ,
    ITP_CMD_STOP
  } itp_kind_e;

  // One queued command; nack only matters for a read
  typedef struct packed {
    itp_kind_e kind;
    logic nack;
    logic [7:0] data;
  } itp_cmd_s;

  localparam int CMD_W = $bits(itp_cmd_s);

  typedef enum logic [2:0] {
    ITP_T_IDLE,
    ITP_T_ADDR,
    ITP_T_WRX,
    ITP_T_RTX,
    ITP_T_WAITP
  } itp_tstate_e;

  typedef enum logic [1:0] {
    ITP_H_IDLE,
    ITP_H_START,
    ITP_H_BIT,
    ITP_H_STOP
  } itp_hstate_e;

endpackage

//--- shared/itp_bus_if.sv
`timescale 1ns/1ps
// Two open-drain lines; each driver only ever pulls low
interface itp_bus_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic t_sda_o;
  logic t_sda_oe;
  logic scl;
  logic sda;

  // Wired-and with pull-up: high unless some enabled driver drives low
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (t_sda_oe & ~t_sda_o));

  modport host (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
    input scl, input sda);
  modport target (output t_sda_o, output t_sda_oe, input scl, input sda);
endinterface

//--- logic/itp_fifo.sv
`timescale 1ns/1ps
module itp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Honest flags straight from the fill count
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_idx];

  // Storage only moves on push, so no reset needed on the array
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wr_idx] <= in_data;
    end
  end

  // Pointers wrap; depth is a power of two
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_idx <= wr_idx + 1'b1;
      end
      if (pop)
      begin
        rd_idx <= rd_idx + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

//--- logic/itp_host_end.sv
`timescale 1ns/1ps
module itp_host_end
  import itp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  itp_bus_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire itp_cmd_s cmd,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack,
  output logic busy
);
  typedef struct packed {
    itp_hstate_e st;
    logic [6:0] tick;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic scl_low;
    logic sda_low;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_ack;
  } itp_host_s;

  itp_host_s r;
  itp_host_s next_r;
  logic [CMD_W-1:0] q_data;
  itp_cmd_s head;
  logic head_valid;
  logic take;
  logic enter;
  logic q_end;

  // Queue lets software post up to eight commands ahead of the slow bus
  itp_fifo #(.WIDTH(CMD_W), .DEPTH(CMD_DEPTH)) u_cmd_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd),
    .out_valid(head_valid),
    .out_ready(take),
    .out_data(q_data)
  );

  assign head = itp_cmd_s'(q_data);
  assign take = (r.st == ITP_H_IDLE);
  assign enter = (r.tick == 7'h00);
  assign q_end = (r.tick == QUARTER_LAST);

  // Lines are open drain: drive low only, release otherwise
  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_scl_oe = r.scl_low;
  assign bus.m_sda_oe = r.sda_low;
  assign rsp_valid = r.rsp_valid;
  assign rsp_data = r.rsp_data;
  assign rsp_ack = r.rsp_ack;
  assign busy = (r.st != ITP_H_IDLE) | head_valid;

  // Each bus step is four quarter periods; actions fire on quarter entry
  always_comb
  begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    if (r.st == ITP_H_IDLE)
    begin
      next_r.tick = 7'h00;
      next_r.q = 2'h0;
      next_r.bitn = 4'h0;
      if (head_valid)
      begin
        case (head.kind)
          ITP_CMD_START: next_r.st = ITP_H_START;
          ITP_CMD_STOP: next_r.st = ITP_H_STOP;
          ITP_CMD_WRITE:
          begin
            next_r.st = ITP_H_BIT;
            next_r.sh = {head.data, 1'b1};
          end
          default:
          begin
            next_r.st = ITP_H_BIT;
            next_r.sh = {8'hff, head.nack};
          end
        endcase
      end
    end
    else
    begin
      next_r.tick = q_end ? 7'h00 : r.tick + 7'h01;
      if (q_end)
      begin
        next_r.q = r.q + 2'h1;
      end
      case (r.st)
        // Works from idle and as a repeated START after a byte
        ITP_H_START:
        begin
          if (enter)
          begin
            case (r.q)
              2'h0: next_r.sda_low = 1'b0;
              2'h1: next_r.scl_low = 1'b0;
              2'h2: next_r.sda_low = 1'b1;
              default: next_r.scl_low = 1'b1;
            endcase
          end
          if (q_end && r.q == 2'h3)
          begin
            next_r.st = ITP_H_IDLE;
          end
        end
        ITP_H_BIT:
        begin
          if (enter)
          begin
            case (r.q)
              2'h0: next_r.sda_low = ~r.sh[8];
              2'h1: next_r.scl_low = 1'b0;
              2'h2: next_r.sh = {r.sh[7:0], bus.sda};
              default:
              begin
                next_r.scl_low = 1'b1;
                if (r.bitn == BYTE_BITS)
                begin
                  next_r.sda_low = 1'b0;
                end
              end
            endcase
          end
          if (q_end && r.q == 2'h3)
          begin
            next_r.bitn = r.bitn + 4'h1;
            if (r.bitn == BYTE_BITS)
            begin
              // Ninth bit done: byte and the acknowledge seen on the line
              next_r.st = ITP_H_IDLE;
              next_r.rsp_valid = 1'b1;
              next_r.rsp_data = r.sh[8:1];
              next_r.rsp_ack = ~r.sh[0];
            end
          end
        end
        default:
        begin
          if (enter)
          begin
            case (r.q)
              2'h0: next_r.sda_low = 1'b1;
              2'h1: next_r.scl_low = 1'b0;
              2'h2: next_r.sda_low = 1'b0;
              default: next_r.sda_low = 1'b0;
            endcase
          end
          if (q_end && r.q == 2'h3)
          begin
            next_r.st = ITP_H_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      r <= '{st: ITP_H_IDLE, default: '0};
    end
    else
    begin
      r <= next_r;
    end
  end
endmodule

//--- logic/itp_target_end.sv
`timescale 1ns/1ps
module itp_target_end
  import itp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  itp_bus_if.target bus,
  output logic [7:0] reg_ptr,
  input wire logic [7:0] reg_rdata,
  output logic wr_valid,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic selected,
  output logic xfer_fail
);
  typedef struct packed {
    itp_tstate_e st;
    logic scl_q;
    logic sda_q;
    logic [3:0] bitn;
    logic ackph;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic ptr_pend;
    logic rw;
    logic mack;
    logic sda_low;
    logic wr_valid;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic fail;
  } itp_tgt_s;

  itp_tgt_s r;
  itp_tgt_s next_r;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic mid_byte;
  logic in_frame;

  // Line events; start and stop need the clock high on both samples
  assign scl_rise = bus.scl & ~r.scl_q;
  assign scl_fall = ~bus.scl & r.scl_q;
  assign start_cond = bus.scl & r.scl_q & r.sda_q & ~bus.sda;
  assign stop_cond = bus.scl & r.scl_q & ~r.sda_q & bus.sda;

  // START or STOP sits legally in the first bit's clock high; any later one cuts a byte
  assign in_frame = (r.st == ITP_T_ADDR) | (r.st == ITP_T_WRX) | (r.st == ITP_T_RTX);
  assign mid_byte = in_frame & ((r.bitn > 4'h1) | r.ackph);

  // Open-drain data: only ever pull low
  assign bus.t_sda_o = 1'b0;
  assign bus.t_sda_oe = r.sda_low;
  assign reg_ptr = r.ptr;
  assign wr_valid = r.wr_valid;
  assign wr_addr = r.wr_addr;
  assign wr_data = r.wr_data;
  assign selected = (r.st == ITP_T_WRX) | (r.st == ITP_T_RTX);
  assign xfer_fail = r.fail;

  // Bit engine: sample on clock rise, drive on clock fall
  always_comb
  begin
    next_r = r;
    next_r.scl_q = bus.scl;
    next_r.sda_q = bus.sda;
    next_r.wr_valid = 1'b0;
    next_r.fail = 1'b0;
    if (stop_cond)
    begin
      // Cut-off byte counts as a failed transfer
      next_r.fail = mid_byte;
      next_r.st = ITP_T_IDLE;
      next_r.sda_low = 1'b0;
      next_r.bitn = 4'h0;
      next_r.ackph = 1'b0;
    end
    else if (start_cond)
    begin
      // Also a repeated START; the pointer survives it
      next_r.fail = mid_byte;
      next_r.st = ITP_T_ADDR;
      next_r.sda_low = 1'b0;
      next_r.bitn = 4'h0;
      next_r.ackph = 1'b0;
    end
    else if (scl_rise && in_frame)
    begin
      if (r.ackph)
      begin
        // Master's answer to our byte; high means it wants no more
        next_r.mack = ~bus.sda;
      end
      else
      begin
        next_r.bitn = r.bitn + 4'h1;
        if (r.st != ITP_T_RTX)
        begin
          next_r.sh = {r.sh[6:0], bus.sda};
        end
      end
    end
    else if (scl_fall && in_frame)
    begin
      case (r.st)
        ITP_T_ADDR:
        begin
          if (r.ackph)
          begin
            next_r.ackph = 1'b0;
            next_r.bitn = 4'h0;
            next_r.sda_low = 1'b0;
            if (r.rw == DIR_READ)
            begin
              // First read byte goes out right as the ack clock ends
              next_r.st = ITP_T_RTX;
              next_r.sh = reg_rdata;
              next_r.ptr = r.ptr + 8'h01;
              next_r.sda_low = ~reg_rdata[DATA_MSB];
            end
            else
            begin
              next_r.st = ITP_T_WRX;
            end
          end
          else if (r.bitn == BYTE_BITS)
          begin
            if (r.sh[7:1] == TGT_ADDR)
            begin
              next_r.ackph = 1'b1;
              next_r.sda_low = 1'b1;
              next_r.rw = r.sh[0];
              next_r.ptr_pend = (r.sh[0] == DIR_WRITE);
            end
            else
            begin
              // Not ours: stay off the line until the next START
              next_r.st = ITP_T_WAITP;
            end
          end
        end
        ITP_T_WRX:
        begin
          if (r.ackph)
          begin
            next_r.ackph = 1'b0;
            next_r.bitn = 4'h0;
            next_r.sda_low = 1'b0;
          end
          else if (r.bitn == BYTE_BITS)
          begin
            next_r.ackph = 1'b1;
            next_r.sda_low = 1'b1;
            if (r.ptr_pend)
            begin
              next_r.ptr = r.sh;
              next_r.ptr_pend = 1'b0;
            end
            else
            begin
              // No byte limit; the pointer simply wraps
              next_r.wr_valid = 1'b1;
              next_r.wr_addr = r.ptr;
              next_r.wr_data = r.sh;
              next_r.ptr = r.ptr + 8'h01;
            end
          end
        end
        default:
        begin
          if (r.ackph)
          begin
            next_r.ackph = 1'b0;
            next_r.bitn = 4'h0;
            if (r.mack)
            begin
              next_r.sh = reg_rdata;
              next_r.ptr = r.ptr + 8'h01;
              next_r.sda_low = ~reg_rdata[DATA_MSB];
            end
            else
            begin
              // Master is done reading; keep the line free
              next_r.st = ITP_T_WAITP;
              next_r.sda_low = 1'b0;
            end
          end
          else if (r.bitn == BYTE_BITS)
          begin
            // Hand the line to the master for its acknowledge
            next_r.ackph = 1'b1;
            next_r.sda_low = 1'b0;
            next_r.mack = 1'b0;
          end
          else
          begin
            next_r.sh = {r.sh[6:0], 1'b1};
            next_r.sda_low = ~r.sh[DATA_MSB-1];
          end
        end
      endcase
    end
  end

  // Line samples reset high so no false edge appears after reset
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      r <= '{st: ITP_T_IDLE, scl_q: 1'b1, sda_q: 1'b1, ptr: PTR_RST, default: '0};
    end
    else
    begin
      r <= next_r;
    end
  end
endmodule

//--- verif/itp_monitor.sv
`timescale 1ns/1ps
// Watches the shared two-wire lines from outside both ends
module itp_monitor
  import itp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic t_sda_o,
  input wire logic t_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic first;
  logic sel;
  logic rd;
  logic done;
  logic [3:0] nbit;
  logic [7:0] sh;
  wire rise = scl & ~scl_q;
  wire fall = ~scl & scl_q;
  wire start = scl & scl_q & sda_q & ~sda;
  wire stop = scl & scl_q & ~sda_q & sda;

  // Bit count and address decode; the clock rise ahead of a repeated start
  // or a stop wraps the count to 1, so framing allows 0 or 1 there
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      nbit <= 4'h0;
      first <= 1'b0;
      sel <= 1'b0;
      rd <= 1'b0;
      done <= 1'b0;
      sh <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start || stop)
      begin
        nbit <= 4'h0;
        first <= start;
        sel <= 1'b0;
        done <= 1'b0;
      end
      else if (rise)
      begin
        nbit <= (nbit == 4'h9) ? 4'h1 : nbit + 4'h1;
        if (nbit < 4'h8)
          sh <= {sh[6:0], sda};
        if (nbit == 4'h8 && sel && rd && sda)
          done <= 1'b1;
      end
      else if (fall && nbit == 4'h9 && first)
      begin
        first <= 1'b0;
        sel <= (sh[7:1] == TGT_ADDR);
        rd <= sh[0];
      end
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Target answers one or two cycles after it sees the clock fall
  sequence s_rel;
    ##[1:2] !t_sda_oe;
  endsequence
  sequence s_pull;
    ##[1:2] t_sda_oe;
  endsequence
  property p_ack;
    fall && nbit == 4'h8 && (first ? sh[7:1] == TGT_ADDR : sel && !rd) |-> s_pull;
  endproperty

  tgt_low_change_a: assert property ($changed(t_sda_oe) |-> !scl)
    else $error("target data moved with clock high");
  ack_pull_a: assert property (p_ack)
    else $error("target missed its acknowledge");
  tx_release_a: assert property (fall && nbit == 4'h8 && sel && rd |-> s_rel)
    else $error("target kept data for read acknowledge");
  ack_release_a: assert property (fall && nbit == 4'h9 && !(first ? sh[0] : rd) |-> s_rel)
    else $error("target kept acknowledge past ninth clock");
  nack_quiet_a: assert property (done |-> !t_sda_oe)
    else $error("target drove after master nack");
  addr_miss_a: assert property ((first && nbit < 4'h8) || (!first && !sel) |-> !t_sda_oe)
    else $error("target drove while not addressed");
  byte_frame_a: assert property (start || stop |-> nbit <= 4'h1)
    else $error("start or stop inside a byte");
  act_low_a: assert property (rise && nbit == 4'h8 && sel && !rd |-> !sda && !t_sda_o)
    else $error("data byte acknowledge not low on the line");
  idle_high_a: assert property ($fell(reset) |-> scl && sda)
    else $error("lines not high after reset");
endmodule

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
  import itp_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  itp_cmd_s cmd = '0;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_ack;
  logic busy;
  logic [7:0] reg_ptr;
  logic [7:0] reg_rdata;
  logic wr_valid;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic xfer_fail;
  logic selected;
  logic [7:0] regs [256];
  logic [7:0] shadow [256];
  logic [15:0] rq [$];
  logic [15:0] wq [$];
  logic [31:0] rnd = 32'h67d6;
  logic full = 1'b0;
  int n_errors = 0;
  int compares = 0;
  int n_fail = 0;

  itp_bus_if bus ();
  itp_host_end u_itp_host_end (
    .clk_sys(clk_sys),
    .reset(reset),
    .bus(bus),
    .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready),
    .cmd(cmd),
    .rsp_valid(rsp_valid),
    .rsp_data(rsp_data),
    .rsp_ack(rsp_ack),
    .busy(busy)
  );
  itp_target_end u_itp_target_end (
    .clk_sys(clk_sys),
    .reset(reset),
    .bus(bus),
    .reg_ptr(reg_ptr),
    .reg_rdata(reg_rdata),
    .wr_valid(wr_valid),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .selected(selected),
    .xfer_fail(xfer_fail)
  );
  itp_monitor u_itp_monitor (.clk_sys(clk_sys), .reset(reset), .t_sda_o(bus.t_sda_o),
    .t_sda_oe(bus.t_sda_oe), .scl(bus.scl), .sda(bus.sda));

  always #12.5 clk_sys = ~clk_sys;

  // Register file behind the target; reads are combinational
  assign reg_rdata = regs[reg_ptr];
  always @(posedge clk_sys)
    if (wr_valid === 1'b1)
      regs[wr_addr] <= wr_data;

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Results come oldest first; an empty queue gives 16'hffff, which no read result can match
  always @(posedge clk_sys)
  begin
    if (rsp_valid === 1'b1)
      chk({7'h0, rsp_ack, rsp_data}, rq.size() ? rq.pop_front() : 16'hffff);
    if (wr_valid === 1'b1)
    begin
      chk({wr_addr, wr_data}, wq.size() ? wq.pop_front() : 16'hffff);
      chk({15'h0, selected}, 16'h1);
    end
    if (xfer_fail === 1'b1)
      n_fail++;
  end

  // Holds the request until the queue takes it; a refusal marks the queue full
  task automatic push(itp_kind_e k, logic n, logic [7:0] d);
    cmd_valid <= 1'b1;
    cmd <= '{k, n, d};
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1)
    begin
      full = 1'b1;
      @(posedge clk_sys);
    end
  endtask

  task automatic wb(logic [7:0] d, logic a);
    rq.push_back({7'h0, a, d});
    push(ITP_CMD_WRITE, 1'b0, d);
  endtask

  // Pointer write then data; a foreign address must see no acknowledge at all
  task automatic xw(logic hit, logic [7:0] p, int n);
    logic [7:0] d;
    push(ITP_CMD_START, 1'b0, 8'h00);
    wb({hit ? TGT_ADDR : 7'h68, DIR_WRITE}, hit);
    wb(p, hit);
    repeat (n)
    begin
      rnd = lfsr(rnd);
      d = rnd[7:0];
      if (hit)
      begin
        wq.push_back({p, d});
        shadow[p] = d;
      end
      wb(d, hit);
      p++;
    end
    push(ITP_CMD_STOP, 1'b0, 8'h00);
  endtask

  // Pointer write, repeated start, reads with a nack on the last byte
  task automatic xr(logic [7:0] p, int n);
    push(ITP_CMD_START, 1'b0, 8'h00);
    wb({TGT_ADDR, DIR_WRITE}, 1'b1);
    wb(p, 1'b1);
    push(ITP_CMD_START, 1'b0, 8'h00);
    wb({TGT_ADDR, DIR_READ}, 1'b1);
    for (int i = 1; i <= n; i++)
    begin
      rq.push_back({7'h0, i != n, shadow[p]});
      push(ITP_CMD_READ, i == n, 8'h00);
      p++;
    end
    push(ITP_CMD_STOP, 1'b0, 8'h00);
  endtask

  task automatic fin(string s, logic [7:0] ptr);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 40000 && busy !== 1'b0; i++)
      @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    // A hung host still shows busy here and counts as a mismatch
    chk({14'h0, busy, selected}, 16'h0);
    chk(16'(rq.size() + wq.size()), 16'h0);
    chk({8'h0, reg_ptr}, {8'h0, ptr});
    $display("test %s done, errors %0d", s, n_errors);
  endtask

  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    xw(1'b1, 8'hfe, 6);
    fin("wrap write", 8'h04);
    chk({15'h0, full}, 16'h1);
    xr(8'hfe, 3);
    fin("restart read", 8'h01);
    xw(1'b0, 8'h10, 1);
    fin("foreign address", 8'h01);
    chk(16'(n_fail), 16'h0);
    test_done();
  end

  // About 64k cycles of traffic are planned
  initial
  begin
    repeat (95000) @(posedge clk_sys);
    n_errors++;
    test_done();
  end
endmodule
